// *** design/period_match_timer_pkg.sv ***
package period_match_timer_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_INDEX = 32'h0000_0FCA;
  localparam logic [31:0] COUNTER_INDEX = 32'h0000_0FCB;
  localparam logic [31:0] PERIOD_INDEX = 32'h0000_0FCC;
  localparam logic [31:0] FLAG_INDEX = 32'h0000_0FCD;
  localparam logic [31:0] ENABLE_INDEX = 32'h0000_0FCE;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned DIV_SEL_LSB = 0;
  localparam int unsigned DIV_SEL_MSB = 1;
  localparam int unsigned RUN_BIT = 2;
  localparam int unsigned POST_SEL_LSB = 3;
  localparam int unsigned POST_SEL_MSB = 6;
  localparam int unsigned IRQ_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and divide codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [1:0] DIV1_CODE = 2'h0;
  localparam logic [1:0] DIV4_CODE = 2'h1;
  localparam logic [3:0] DIV1_LAST = 4'h0;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hF;

  // ----------------------------------------------------------------
  // Timing: oscillator clock cycles per instruction clock
  // ----------------------------------------------------------------
  localparam int unsigned OSC_PER_INSTR = 4;
  localparam logic [1:0] INSTR_LAST = 2'(OSC_PER_INSTR - 1);

  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_COUNTER,
    SEL_PERIOD,
    SEL_FLAG,
    SEL_ENABLE
  } reg_sel_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT
  } bus_state_t;

  typedef struct packed {
    bus_state_t bus;
    reg_sel_t sel;
    logic [6:0] ctrl;
    logic [7:0] counter;
    logic [7:0] period;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic flag;
    logic irq_en;
    logic [31:0] hrdata;
    logic hready;
    logic irq;
    logic timebase;
    logic shift_clk;
  } timer_state_t;

  typedef struct packed {
    logic [1:0] phase;
    logic tick;
  } divider_state_t;

endpackage

// *** design/instr_clock_divider.sv ***
module instr_clock_divider (
  input wire logic clk_in,       // Oscillator clock
  input wire logic reset_n_in,   // Async reset, active low
  output logic tick_out          // One-cycle pulse per instruction clock
);

  period_match_timer_pkg::divider_state_t state_reg;
  period_match_timer_pkg::divider_state_t state_next;

  // Free-running quarter divider
  always_comb begin
    state_next = state_reg;
    state_next.tick = (state_reg.phase == period_match_timer_pkg::INSTR_LAST);
    if (state_reg.phase == period_match_timer_pkg::INSTR_LAST) begin
      state_next.phase = 2'h0;
    end else begin
      state_next.phase = state_reg.phase + 2'h1;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_out = state_reg.tick;

endmodule

// *** design/period_match_timer.sv ***
// Operation
// - Counter counts up from zero on prescaled instruction clocks (oscillator divided by four)
// - Divide select bits 1:0: code 00 divides by 1, 01 by 4, 10 by 16
// - Counter is compared with period value every cycle; equality gives match
// - Match reloads counter with zero next count and advances postscaler
// - Reset clears counter and presets period value to all ones
// - Counter write, control write or reset clear prescaler and postscaler
// - Control write leaves counter value unchanged
// - Counter and period value are directly readable and writable
// - Match divide bits 6:3 select postscale of one plus value
// - Run bit 2 turns the timer on when set, off when clear
// - After selected match count, flag bit 1 is set and held
// - Interrupt requested from flag only while enable bit 1 is set
// - Unscaled match drives the PWM time base output
// - Match also offered as optional serial shift clock
//
// Chosen here: register access over AHB-Lite.
module period_match_timer (
  input wire logic clk_in,             // Oscillator clock, 25 MHz
  input wire logic reset_n_in,         // Async reset, active low
  input wire logic hsel_in,            // Slave select
  input wire logic [31:0] haddr_in,    // Byte address
  input wire logic [1:0] htrans_in,    // Transfer type
  input wire logic hwrite_in,          // Write when high
  input wire logic [2:0] hsize_in,     // Transfer size, word only
  input wire logic [31:0] hwdata_in,   // Write data
  input wire logic hready_in,          // Bus ready
  output logic [31:0] hrdata_out,      // Read data
  output logic hreadyout_out,          // Slave ready
  output logic hresp_out,              // Always OKAY
  output logic irq_out,                // Level interrupt
  output logic pwm_timebase_out,       // Unscaled match pulse
  output logic shift_clk_out           // Match-toggled shift clock
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  period_match_timer_pkg::timer_state_t state_reg;
  period_match_timer_pkg::timer_state_t state_next;
  logic instr_tick;
  logic take_request;
  logic count_tick;
  logic match;
  logic [3:0] pre_last;
  logic [3:0] post_last;
  logic run;

  // ----------------------------------------------------------------
  // Instruction clock
  // ----------------------------------------------------------------
  instr_clock_divider u_instr_div (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .tick_out(instr_tick)
  );

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Byte address to register select
  function automatic period_match_timer_pkg::reg_sel_t decode(input logic [31:0] addr);
    logic [31:0] idx;
    idx = {2'b00, addr[31:2]};
    if (addr[1:0] != 2'b00) begin
      decode = period_match_timer_pkg::SEL_NONE;
    end else if (idx == period_match_timer_pkg::CTRL_INDEX) begin
      decode = period_match_timer_pkg::SEL_CTRL;
    end else if (idx == period_match_timer_pkg::COUNTER_INDEX) begin
      decode = period_match_timer_pkg::SEL_COUNTER;
    end else if (idx == period_match_timer_pkg::PERIOD_INDEX) begin
      decode = period_match_timer_pkg::SEL_PERIOD;
    end else if (idx == period_match_timer_pkg::FLAG_INDEX) begin
      decode = period_match_timer_pkg::SEL_FLAG;
    end else if (idx == period_match_timer_pkg::ENABLE_INDEX) begin
      decode = period_match_timer_pkg::SEL_ENABLE;
    end else begin
      decode = period_match_timer_pkg::SEL_NONE;
    end
  endfunction

  // Prescaler terminal count from divide select
  function automatic logic [3:0] prescale_last(input logic [1:0] code);
    unique case (code)
      period_match_timer_pkg::DIV1_CODE: prescale_last = period_match_timer_pkg::DIV1_LAST;
      period_match_timer_pkg::DIV4_CODE: prescale_last = period_match_timer_pkg::DIV4_LAST;
      default: prescale_last = period_match_timer_pkg::DIV16_LAST;
    endcase
  endfunction

  // Read multiplexer
  function automatic logic [31:0] read_value(input period_match_timer_pkg::timer_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (s.sel)
      period_match_timer_pkg::SEL_CTRL: v[6:0] = s.ctrl;
      period_match_timer_pkg::SEL_COUNTER: v[7:0] = s.counter;
      period_match_timer_pkg::SEL_PERIOD: v[7:0] = s.period;
      period_match_timer_pkg::SEL_FLAG: v[period_match_timer_pkg::IRQ_BIT] = s.flag;
      period_match_timer_pkg::SEL_ENABLE: v[period_match_timer_pkg::IRQ_BIT] = s.irq_en;
      period_match_timer_pkg::SEL_NONE: v = 32'h0000_0000;
      default: v = 32'h0000_0000;
    endcase
    read_value = v;
  endfunction

  // ----------------------------------------------------------------
  // Timer datapath decode
  // ----------------------------------------------------------------

  // Control fields and count enable
  assign run = state_reg.ctrl[period_match_timer_pkg::RUN_BIT];
  assign pre_last = prescale_last(
    state_reg.ctrl[period_match_timer_pkg::DIV_SEL_MSB:period_match_timer_pkg::DIV_SEL_LSB]);
  assign post_last =
    state_reg.ctrl[period_match_timer_pkg::POST_SEL_MSB:period_match_timer_pkg::POST_SEL_LSB];
  assign count_tick = run && instr_tick && (state_reg.pre_cnt == pre_last);
  assign match = (state_reg.counter == state_reg.period);

  // Address phase accepted
  assign take_request = hsel_in && hready_in && htrans_in[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.timebase = 1'b0;
    state_next.hready = 1'b1;

    // Prescaler on instruction clocks while running
    if (run && instr_tick) begin
      if (state_reg.pre_cnt == pre_last) begin
        state_next.pre_cnt = 4'h0;
      end else begin
        state_next.pre_cnt = state_reg.pre_cnt + 4'h1;
      end
    end

    // Count, match reload and postscaler
    if (count_tick) begin
      if (match) begin
        state_next.counter = period_match_timer_pkg::COUNTER_RESET;
        state_next.timebase = 1'b1;
        state_next.shift_clk = ~state_reg.shift_clk;
        if (state_reg.post_cnt == post_last) begin
          state_next.post_cnt = 4'h0;
          state_next.flag = 1'b1;
        end else begin
          state_next.post_cnt = state_reg.post_cnt + 4'h1;
        end
      end else begin
        state_next.counter = state_reg.counter + 8'h01;
      end
    end

    // Bus data phase effects
    unique case (state_reg.bus)
      period_match_timer_pkg::BUS_WRITE: begin
        unique case (state_reg.sel)
          period_match_timer_pkg::SEL_CTRL: begin
            state_next.ctrl = hwdata_in[6:0];
            state_next.pre_cnt = 4'h0;
            state_next.post_cnt = 4'h0;
            state_next.counter = state_reg.counter;
          end
          period_match_timer_pkg::SEL_COUNTER: begin
            state_next.counter = hwdata_in[7:0];
            state_next.pre_cnt = 4'h0;
            state_next.post_cnt = 4'h0;
          end
          period_match_timer_pkg::SEL_PERIOD: begin
            state_next.period = hwdata_in[7:0];
          end
          period_match_timer_pkg::SEL_FLAG: begin
            // Write one clears; a same-cycle set wins
            if (hwdata_in[period_match_timer_pkg::IRQ_BIT] && !state_next.flag) begin
              state_next.flag = 1'b0;
            end else if (hwdata_in[period_match_timer_pkg::IRQ_BIT] &&
                         !(count_tick && match && state_reg.post_cnt == post_last)) begin
              state_next.flag = 1'b0;
            end
          end
          period_match_timer_pkg::SEL_ENABLE: begin
            state_next.irq_en = hwdata_in[period_match_timer_pkg::IRQ_BIT];
          end
          period_match_timer_pkg::SEL_NONE: begin
            state_next.sel = period_match_timer_pkg::SEL_NONE;
          end
          default: begin
            state_next.sel = period_match_timer_pkg::SEL_NONE;
          end
        endcase
      end
      period_match_timer_pkg::BUS_READ_WAIT: begin
        state_next.hrdata = read_value(state_reg);
      end
      period_match_timer_pkg::BUS_IDLE: begin
        state_next.hrdata = state_reg.hrdata;
      end
      default: begin
        state_next.hrdata = state_reg.hrdata;
      end
    endcase

    // Address phase capture
    state_next.bus = period_match_timer_pkg::BUS_IDLE;
    if (take_request) begin
      state_next.sel = decode(haddr_in);
      if (hwrite_in) begin
        state_next.bus = period_match_timer_pkg::BUS_WRITE;
      end else begin
        state_next.bus = period_match_timer_pkg::BUS_READ_WAIT;
        state_next.hready = 1'b0;
      end
    end

    // Masked interrupt level
    state_next.irq = state_next.flag && state_next.irq_en;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
      state_reg.bus <= period_match_timer_pkg::BUS_IDLE;
      state_reg.sel <= period_match_timer_pkg::SEL_NONE;
      state_reg.ctrl <= period_match_timer_pkg::CTRL_RESET;
      state_reg.counter <= period_match_timer_pkg::COUNTER_RESET;
      state_reg.period <= period_match_timer_pkg::PERIOD_RESET;
      state_reg.hready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata_out = state_reg.hrdata;
  assign hreadyout_out = state_reg.hready;
  assign hresp_out = period_match_timer_pkg::HRESP_OKAY;
  assign irq_out = state_reg.irq;
  assign pwm_timebase_out = state_reg.timebase;
  assign shift_clk_out = state_reg.shift_clk;

endmodule

// *** tb/period_match_timer_chk.sv ***
module period_match_timer_chk (
  input wire logic clk_in,            // Clock
  input wire logic reset_n_in,        // Reset, active low
  input wire logic hsel_in,           // Select
  input wire logic [31:0] haddr_in,   // Address
  input wire logic [1:0] htrans_in,   // Transfer type
  input wire logic hwrite_in,         // Write
  input wire logic [31:0] hwdata_in,  // Write data
  input wire logic hready_in,         // Bus ready
  input wire logic [31:0] hrdata_out, // Read data
  input wire logic hreadyout_out,     // Slave ready
  input wire logic hresp_out,         // Response
  input wire logic irq_out,           // Interrupt
  input wire logic pwm_timebase_out,  // Match pulse
  input wire logic shift_clk_out      // Shift clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Helper state and assertions
  // ----------------------------------------------------------------
  logic wr_ph, ctl_ph, run_q, seen;
  logic [1:0] gap;
  wire take = hsel_in && hready_in && htrans_in[1];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Track write phases, run bit and spacing since last match
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ph <= 1'b0;
      ctl_ph <= 1'b0;
      run_q <= 1'b0;
      seen <= 1'b0;
      gap <= 2'h0;
    end else begin
      wr_ph <= take && hwrite_in;
      ctl_ph <= take && hwrite_in && haddr_in == (period_match_timer_pkg::CTRL_INDEX << 2);
      if (ctl_ph) begin
        run_q <= hwdata_in[period_match_timer_pkg::RUN_BIT];
      end
      seen <= seen | pwm_timebase_out;
      gap <= pwm_timebase_out ? 2'h0 : gap + 2'h1;
    end
  end
  sequence rd_take;
    take && !hwrite_in;
  endsequence
  sequence rd_answer;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  chk_read_wait: assert property (rd_take |=> rd_answer)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite_in |=> hreadyout_out)
    else $error("write stalled");
  chk_data_hold: assert property ($changed(hrdata_out) |-> $rose(hreadyout_out))
    else $error("read data moved outside a read");
  chk_resp_okay: assert property (!hresp_out)
    else $error("response not okay");
  chk_pulse_single: assert property (pwm_timebase_out |=> !pwm_timebase_out [*3])
    else $error("match pulse too long or too close");
  chk_tick_grid: assert property (seen && pwm_timebase_out |-> gap == 2'h3)
    else $error("match off the instruction grid");
  chk_shift_toggle: assert property ($changed(shift_clk_out) |-> pwm_timebase_out)
    else $error("shift clock moved without match");
  chk_irq_rise: assert property ($rose(irq_out) |-> pwm_timebase_out || $past(wr_ph))
    else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(irq_out) |-> $past(wr_ph))
    else $error("interrupt dropped without write");
  chk_stop_quiet: assert property (!run_q && !$past(run_q) |-> !pwm_timebase_out)
    else $error("match while stopped");
endmodule

bind period_match_timer period_match_timer_chk chk_i (.clk_in, .reset_n_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
  .hresp_out, .irq_out, .pwm_timebase_out, .shift_clk_out);

// *** tb/match_sink.sv ***
module match_sink (
  input wire logic clk_in,        // Clock
  input wire logic reset_n_in,    // Reset, active low
  input wire logic timebase_in,   // Match pulse
  input wire logic shift_clk_in,  // Shift clock
  output logic [15:0] pulses_out, // Matches seen
  output logic [15:0] gap_out,    // Clocks between last two matches
  output logic [15:0] edges_out   // Shift clock edges seen
);
  // ----------------------------------------------------------------
  // PWM time base and shift clock consumer
  // ----------------------------------------------------------------
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_cnt;
  logic shift_q;
  // Count matches, their spacing and shift clock edges
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulses_out <= 16'h0;
      gap_out <= 16'h0;
      edges_out <= 16'h0;
      run_cnt <= 16'h0;
      shift_q <= 1'b0;
    end else begin
      run_cnt <= timebase_in ? 16'h0 : run_cnt + 16'h1;
      if (timebase_in) begin
        pulses_out <= pulses_out + 16'h1;
        gap_out <= run_cnt + 16'h1;
      end
      if (shift_clk_in != shift_q) begin
        edges_out <= edges_out + 16'h1;
      end
      shift_q <= shift_clk_in;
    end
  end
endmodule

// *** tb/testbench.sv ***
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus, tasks and sequence
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL = period_match_timer_pkg::CTRL_INDEX;
  localparam logic [31:0] CNT = period_match_timer_pkg::COUNTER_INDEX;
  localparam logic [31:0] PER = period_match_timer_pkg::PERIOD_INDEX;
  localparam logic [31:0] FLG = period_match_timer_pkg::FLAG_INDEX;
  localparam logic [31:0] ENA = period_match_timer_pkg::ENABLE_INDEX;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, v;
  logic hready, irq, tbase, sclk, hresp;
  logic [15:0] pulses, gap, edges, n;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 1;
  // Free-running clock
  always #20 clk_in = ~clk_in;
  period_match_timer period_match_timer_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .irq_out(irq), .pwm_timebase_out(tbase),
    .shift_clk_out(sclk));
  match_sink match_sink_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .timebase_in(tbase),
    .shift_clk_in(sclk), .pulses_out(pulses), .gap_out(gap), .edges_out(edges));
  function automatic logic [15:0] exp_gap(input logic [1:0] c, input logic [7:0] p);
    exp_gap = 16'((p + 1) * (c == 2'h0 ? 1 : c == 2'h1 ? 4 : 16) * 4);
  endfunction
  task automatic bus(input logic w, input logic [31:0] ix, input logic [31:0] d);
    @(posedge clk_in);
    htrans <= period_match_timer_pkg::HTRANS_NONSEQ;
    haddr <= ix << 2;
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd_chk(input string s, input logic [31:0] ix, input logic [31:0] e);
    bus(1'b0, ix, 32'h0);
    `CHK(s, e, q)
    `CHK("response", period_match_timer_pkg::HRESP_OKAY, hresp)
  endtask
  task automatic do_reset;
    reset_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
  endtask
  task automatic check_reset;
    logic [7:0] e [5];
    e = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd_chk("reset value", CTL + 32'(i), {24'h0, e[i]});
    end
  endtask
  task automatic irq_chk(input logic e);
    @(negedge clk_in);
    `CHK("interrupt", e, irq)
  endtask
  task tally_and_finish;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #2000000;
    err_count++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    do_reset;
    check_reset;
    rd_chk("unmapped", 32'h0FC9, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      bus(1'b1, PER, {24'h0, v[7:0]});
      rd_chk("period", PER, {24'h0, v[7:0]});
      bus(1'b1, CNT, {24'h0, v[15:8]});
      bus(1'b1, CTL, v & 32'h7B);
      rd_chk("counter kept", CNT, {24'h0, v[15:8]});
      rd_chk("control", CTL, v & 32'h7B);
    end
    for (int c = 0; c < 4; c++) begin
      v = $random(seed) & 32'h7;
      bus(1'b1, PER, v);
      bus(1'b1, CNT, 32'h0);
      bus(1'b1, CTL, 32'h4 | 32'(c));
      n = pulses;
      for (int i = 0; i < 4000 && pulses < n + 16'd3; i++) @(posedge clk_in);
      @(negedge clk_in);
      `CHK("match count", 1'b1, pulses >= n + 16'd3)
      `CHK("match spacing", exp_gap(2'(c), v[7:0]), gap)
      bus(1'b1, CTL, 32'h0);
      `CHK("shift edges", pulses, edges)
    end
    v = $random(seed) & 32'hF;
    bus(1'b1, ENA, 32'h2);
    bus(1'b1, FLG, 32'h2);
    bus(1'b1, PER, 32'h1);
    bus(1'b1, CNT, 32'h0);
    n = pulses;
    bus(1'b1, CTL, (v << 3) | 32'h4);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("flag reached", 1'b1, irq)
    `CHK("matches per flag", v[15:0] + 16'h1, pulses - n)
    bus(1'b1, CTL, 32'h0);
    bus(1'b1, ENA, 32'h0);
    irq_chk(1'b0);
    rd_chk("flag", FLG, 32'h2);
    bus(1'b1, ENA, 32'h2);
    irq_chk(1'b1);
    bus(1'b1, FLG, 32'h2);
    irq_chk(1'b0);
    bus(1'b0, CNT, 32'h0);
    v = q;
    n = pulses;
    repeat (200) @(posedge clk_in);
    rd_chk("stopped counter", CNT, v);
    `CHK("stopped matches", n, pulses)
    // Counter write mid-run restarts the postscaler
    bus(1'b1, CTL, 32'h1C);
    n = pulses;
    for (int i = 0; i < 100 && pulses < n + 16'd2; i++) @(posedge clk_in);
    bus(1'b1, CNT, 32'h0);
    n = pulses;
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("flag after restart", 1'b1, irq)
    `CHK("matches after write", 16'h4, pulses - n)
    bus(1'b1, CTL, 32'h0);
    bus(1'b1, FLG, 32'h2);
    bus(1'b1, CTL, 32'h4);
    repeat (50) @(posedge clk_in);
    do_reset;
    check_reset;
    tally_and_finish;
  end
endmodule
